/* logic/qdsc_top.sv */
// Serial control logic of a four channel converter
//
// Behaviour
// - Capture one data bit on each falling serial clock edge after select falls.
// - Frame is 24 bits; execute at the 24th falling edge.
// - Longer frames execute at edge 24; extra bits ignored.
// - Select rising before 24 edges discards the frame.
// - Serial clock ignored while select is high.
// - Frame is command byte then left-justified offset-binary 16-bit word.
// - Each channel has a pending register feeding an output latch.
// - Latch loads directly on write-and-transfer or from pending on transfer.
// - Registers keep contents and update during power-down.
// - Soft zero and soft default clear all pending and output registers.
// - Power-on sets all channel registers to code zero.
// - Reference mode defaults to external after power-on and soft default.
// - Load pin low copies every channel's pending into its output latch.
// - Load pin held low makes latches transparent.
// - Config command sets the latch gate bit of channels picked by bits 11..8, or of all with bit 19.
// - Zero pin low clears all pending and output registers.
// - Zero pin low cancels any frame in progress.
// - Ready output goes low at the 24th falling edge.
// - Command bits 23..20 choose write, transfer, write-transfer-all, write-transfer-selected, power, soft, config, reference, all-group.
// - Transfer-all copies every pending register into its latch.
// - Gate bit 0 latches on transfers only; 1 makes latch transparent.
// - Ready output returns high after select rises.
`timescale 1ns/10ps
module qdsc_top (
  input  wire logic                        clk,
  input  wire logic                        rstn,
  input  wire logic                        ce,
  input  wire logic                        select_n,
  input  wire logic                        sclk,
  input  wire logic                        din,
  input  wire logic                        hw_transfer_n,
  input  wire logic                        async_zero_n,
  output logic                             ready_n,
  output logic [qdsc_pkg::RES_BITS-1:0]    out_a,
  output logic [qdsc_pkg::RES_BITS-1:0]    out_b,
  output logic [qdsc_pkg::RES_BITS-1:0]    out_c,
  output logic [qdsc_pkg::RES_BITS-1:0]    out_d,
  output logic [1:0]                       ref_mode,
  output logic                             ref_always_on,
  output logic [7:0]                       power_mode,
  output logic [qdsc_pkg::NUM_CH-1:0]      latch_gate
);

  localparam int NCH = qdsc_pkg::NUM_CH;
  localparam int RB  = qdsc_pkg::RES_BITS;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic sel_s, sclk_s, din_s, hwx_s, zero_s;

  qdsc_sync #(.RESET_VAL(1'b1)) u_sync_sel (
    .clk(clk), .rstn(rstn), .ce(ce), .d(select_n), .q(sel_s));
  qdsc_sync #(.RESET_VAL(1'b0)) u_sync_sclk (
    .clk(clk), .rstn(rstn), .ce(ce), .d(sclk), .q(sclk_s));
  qdsc_sync #(.RESET_VAL(1'b0)) u_sync_din (
    .clk(clk), .rstn(rstn), .ce(ce), .d(din), .q(din_s));
  qdsc_sync #(.RESET_VAL(1'b1)) u_sync_hwx (
    .clk(clk), .rstn(rstn), .ce(ce), .d(hw_transfer_n), .q(hwx_s));
  qdsc_sync #(.RESET_VAL(1'b1)) u_sync_zero (
    .clk(clk), .rstn(rstn), .ce(ce), .d(async_zero_n), .q(zero_s));

  // ----------------------------------------------------------------
  // Edge detection on the synchronised serial clock
  // ----------------------------------------------------------------
  logic sclk_d;
  logic sel_d;
  logic sclk_fall;

  // Previous samples; a frame opens only on a select fall, never on a level
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sclk_d <= 1'b0;
      sel_d  <= 1'b1;
    end else if (ce) begin
      sclk_d <= sclk_s;
      sel_d  <= sel_s;
    end
  end

  // Edges count only while selected and not held in zero
  assign sclk_fall = sclk_d & ~sclk_s & ~sel_s & zero_s;

  // ----------------------------------------------------------------
  // Frame receiver
  // ----------------------------------------------------------------
  qdsc_pkg::qdsc_state_t state, next_state;
  logic [4:0]                          bit_cnt;
  logic [qdsc_pkg::FRAME_BITS-1:0]     shreg;
  logic                                exec;

  // Decide the next frame state
  always_comb begin
    next_state = state;
    case (state)
      qdsc_pkg::QDSC_IDLE: begin
        if (sel_d && !sel_s && zero_s) begin
          next_state = qdsc_pkg::QDSC_SHIFT;
        end
      end
      qdsc_pkg::QDSC_SHIFT: begin
        if (sel_s || !zero_s) begin
          next_state = qdsc_pkg::QDSC_IDLE;
        end else if (sclk_fall && bit_cnt == qdsc_pkg::LAST_BIT_IDX) begin
          next_state = qdsc_pkg::QDSC_DONE;
        end
      end
      qdsc_pkg::QDSC_DONE: begin
        // Stay until select rises or zero drops, ignoring extra bits
        if (sel_s || !zero_s) begin
          next_state = qdsc_pkg::QDSC_IDLE;
        end
      end
      default: next_state = qdsc_pkg::QDSC_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= qdsc_pkg::QDSC_IDLE;
    end else if (ce) begin
      state <= next_state;
    end
  end

  // Bit counter cleared outside the shift state; shift register is cleared only by reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bit_cnt <= 5'h00;
      shreg   <= 24'h000000;
    end else if (ce) begin
      if (state != qdsc_pkg::QDSC_SHIFT) begin
        bit_cnt <= 5'h00;
      end else if (sclk_fall) begin
        bit_cnt <= bit_cnt + 5'h01;
        shreg   <= {shreg[qdsc_pkg::FRAME_BITS-2:0], din_s};
      end
    end
  end

  // Execute pulse one cycle after the 24th edge is shifted in
  assign exec = (state == qdsc_pkg::QDSC_DONE) && (bit_cnt == 5'h18)
                && zero_s;

  // Mark execution so it happens only once per frame
  logic done_seen;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      done_seen <= 1'b0;
    end else if (ce) begin
      done_seen <= (state == qdsc_pkg::QDSC_DONE);
    end
  end

  logic exec_p;
  assign exec_p = exec & ~done_seen;

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  logic [7:0]      cmd;
  logic [3:0]      op;
  logic [RB-1:0]   code;
  logic [NCH-1:0]  sel_ch, wr, xf, dir;
  logic            soft_zero, soft_def;

  assign cmd  = shreg[23:16];
  assign op   = cmd[7:4];
  assign code = shreg[15:16-RB];

  // Channel selection: values above 3 mean all channels
  always_comb begin
    sel_ch = 4'h0;
    if (cmd[3] || cmd[2]) begin
      sel_ch = 4'hf;
    end else begin
      sel_ch[cmd[1:0]] = 1'b1;
    end
  end

  // Per-channel write, transfer and direct-load strobes
  always_comb begin
    wr  = 4'h0;
    xf  = 4'h0;
    dir = 4'h0;
    if (exec_p) begin
      case (op)
        qdsc_pkg::OP_WRITE_PENDING: wr = sel_ch;
        qdsc_pkg::OP_XFER_SELECTED: xf = sel_ch;
        qdsc_pkg::OP_WRITE_XFER_ALL: begin
          wr  = sel_ch;
          dir = sel_ch;
          xf  = ~sel_ch;
        end
        qdsc_pkg::OP_WRITE_XFER_SEL: begin
          wr  = sel_ch;
          dir = sel_ch;
        end
        qdsc_pkg::OP_ALL_GROUP: begin
          if (cmd == qdsc_pkg::CMD_WRITE_ALL) begin
            wr = 4'hf;
          end else if (cmd == qdsc_pkg::CMD_XFER_ALL) begin
            xf = 4'hf;
          end else if (cmd[7:1] == qdsc_pkg::CMD_WRITE_XFER_ALL_HI) begin
            wr  = 4'hf;
            dir = 4'hf;
          end
        end
        default: begin
          wr = 4'h0;
        end
      endcase
    end
  end

  assign soft_zero = exec_p && (cmd == qdsc_pkg::CMD_SOFT_ZERO);
  assign soft_def  = exec_p && (cmd == qdsc_pkg::CMD_SOFT_DEFAULT);

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // Gate bits, power modes, reference selection
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      latch_gate    <= qdsc_pkg::GATE_RESET;
      power_mode    <= {4{qdsc_pkg::PWR_NORMAL}};
      ref_mode      <= qdsc_pkg::REF_EXTERNAL;
      ref_always_on <= 1'b0;
    end else if (ce) begin
      if (soft_def) begin
        latch_gate    <= qdsc_pkg::GATE_RESET;
        power_mode    <= {4{qdsc_pkg::PWR_NORMAL}};
        ref_mode      <= qdsc_pkg::REF_EXTERNAL;
        ref_always_on <= 1'b0;
      end else if (exec_p && op == qdsc_pkg::OP_CONFIG) begin
        for (int i = 0; i < NCH; i++) begin
          if (shreg[19] || shreg[8+i]) begin
            latch_gate[i] <= shreg[16];
          end
        end
      end else if (exec_p && op == qdsc_pkg::OP_POWER) begin
        for (int i = 0; i < NCH; i++) begin
          if (shreg[8+i]) begin
            power_mode[2*i +: 2] <= shreg[17:16];
          end
        end
      end else if (exec_p && op == qdsc_pkg::OP_REFERENCE) begin
        ref_mode      <= shreg[17:16];
        ref_always_on <= shreg[18];
      end
    end
  end

  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------
  logic            zero_all, hw_load;
  logic [RB-1:0]   ch_out [NCH];

  assign zero_all = ~zero_s | soft_zero | soft_def;
  assign hw_load  = ~hwx_s;

  for (genvar g = 0; g < NCH; g++) begin : g_ch
    qdsc_channel u_ch (
      .clk       (clk),
      .rstn      (rstn),
      .ce        (ce),
      .zero      (zero_all),
      .write_en  (wr[g]),
      .write_data(code),
      .xfer_en   (xf[g]),
      .direct_en (dir[g]),
      .hw_load   (hw_load),
      .gate      (latch_gate[g]),
      .pending   (),
      .out_latch (ch_out[g])
    );
  end

  // Outputs registered again so they come straight from flops
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      out_a <= qdsc_pkg::CODE_RESET;
      out_b <= qdsc_pkg::CODE_RESET;
      out_c <= qdsc_pkg::CODE_RESET;
      out_d <= qdsc_pkg::CODE_RESET;
    end else if (ce) begin
      out_a <= ch_out[0];
      out_b <= ch_out[1];
      out_c <= ch_out[2];
      out_d <= ch_out[3];
    end
  end

  // ----------------------------------------------------------------
  // Ready output for daisy chain
  // ----------------------------------------------------------------
  // Low from the 24th edge until select rises
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ready_n <= 1'b1;
    end else if (ce) begin
      if (sel_s) begin
        ready_n <= 1'b1;
      end else if (state == qdsc_pkg::QDSC_SHIFT && sclk_fall
                   && bit_cnt == qdsc_pkg::LAST_BIT_IDX) begin
        ready_n <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  AST_READY_HIGH_IDLE: assert property (ce && sel_s |=> ready_n)
    else $error("ready low while deselected");
  AST_READY_AT_24: assert property (ce && state == qdsc_pkg::QDSC_SHIFT
      && sclk_fall && bit_cnt == 5'h17 && !sel_s |=> !ready_n)
    else $error("ready not low at last edge");
  AST_EXEC_NEEDS_24: assert property (exec_p |-> !ready_n
      && bit_cnt == 5'h18)
    else $error("execute without full frame");
  AST_NO_EXEC_DESEL: assert property (exec_p |-> $past(!sel_s))
    else $error("execute after select rose");
  AST_ZERO_CLEARS: assert property (ce && !zero_s |=> ch_out[0] == '0
      && ch_out[3] == '0)
    else $error("zero pin did not clear");
  AST_ZERO_ABORTS: assert property (ce && !zero_s |=>
      state == qdsc_pkg::QDSC_IDLE)
    else $error("frame not aborted by zero");
  AST_SOFT_ZERO: assert property (ce && soft_zero |=> ch_out[1] == '0)
    else $error("soft zero ignored");
  AST_REF_DEFAULT: assert property (ce && soft_def |=>
      ref_mode == qdsc_pkg::REF_EXTERNAL)
    else $error("reference not external after soft default");
  AST_IGNORE_DESEL: assert property (sel_s |=> $stable(shreg))
    else $error("clock used while deselected");

  COV_FRAME_EXEC: cover property (exec_p);
  COV_ABORT: cover property (state == qdsc_pkg::QDSC_SHIFT && sel_s
      && bit_cnt != 5'h00);
  COV_HW_LOAD: cover property (hw_load && ce);
  COV_LONG_FRAME: cover property (state == qdsc_pkg::QDSC_DONE && sclk_d
      && !sclk_s && !sel_s);

endmodule : qdsc_top

/* pkg/qdsc_pkg.sv */
// Package: constants and types for the quad converter serial control block
package qdsc_pkg;

  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam int          FRAME_BITS   = 24;
  localparam logic [4:0]  LAST_BIT_IDX = 5'h17;   // 24th falling edge
  localparam int          NUM_CH       = 4;
  localparam int          WORD_W       = 16;
  localparam int          RES_BITS     = 12;       // 8, 10 or 12

  // ----------------------------------------------------------------
  // Command nibble (bits 23..20)
  // ----------------------------------------------------------------
  localparam logic [3:0] OP_WRITE_PENDING = 4'h0;
  localparam logic [3:0] OP_XFER_SELECTED = 4'h1;
  localparam logic [3:0] OP_WRITE_XFER_ALL = 4'h2;
  localparam logic [3:0] OP_WRITE_XFER_SEL = 4'h3;
  localparam logic [3:0] OP_POWER         = 4'h4;
  localparam logic [3:0] OP_SOFT          = 4'h5;
  localparam logic [3:0] OP_CONFIG        = 4'h6;
  localparam logic [3:0] OP_REFERENCE     = 4'h7;
  localparam logic [3:0] OP_ALL_GROUP     = 4'h8;

  // Full command byte codes
  localparam logic [7:0] CMD_SOFT_ZERO    = 8'h50;
  localparam logic [7:0] CMD_SOFT_DEFAULT = 8'h51;
  localparam logic [7:0] CMD_WRITE_ALL    = 8'h80;
  localparam logic [7:0] CMD_XFER_ALL     = 8'h81;
  localparam logic [6:0] CMD_WRITE_XFER_ALL_HI = 7'h41; // 1000001x

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [RES_BITS-1:0] CODE_RESET  = 12'h000;
  localparam logic [1:0]          REF_EXTERNAL = 2'h0;
  localparam logic [1:0]          PWR_NORMAL   = 2'h0;
  localparam logic [NUM_CH-1:0]   GATE_RESET   = 4'h0;

  // ----------------------------------------------------------------
  // Timing (host obligations, used for documentation of the bench)
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int ZERO_RELEASE_TO_SELECT_GAP_NS = 20;
  localparam int ZERO_RELEASE_TO_SELECT_GAP_CYC =
    (ZERO_RELEASE_TO_SELECT_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Frame receiver state
  typedef enum logic [2:0] {
    QDSC_IDLE  = 3'b001,
    QDSC_SHIFT = 3'b010,
    QDSC_DONE  = 3'b100
  } qdsc_state_t;

endpackage : qdsc_pkg

/* logic/qdsc_sync.sv */
// Two flip-flop synchroniser for one asynchronous input
`timescale 1ns/10ps
module qdsc_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic ce,
  input  wire logic d,
  output logic      q
);

  logic meta;

  // ------------------------------------------------------------
  // Stages
  // ------------------------------------------------------------
  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta <= RESET_VAL;
      q    <= RESET_VAL;
    end else if (ce) begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule : qdsc_sync

/* logic/qdsc_channel.sv */
// One converter channel: pending register and output latch
`timescale 1ns/10ps
module qdsc_channel (
  input  wire logic                          clk,
  input  wire logic                          rstn,
  input  wire logic                          ce,
  input  wire logic                          zero,
  input  wire logic                          write_en,
  input  wire logic [qdsc_pkg::RES_BITS-1:0] write_data,
  input  wire logic                          xfer_en,
  input  wire logic                          direct_en,
  input  wire logic                          hw_load,
  input  wire logic                          gate,
  output logic      [qdsc_pkg::RES_BITS-1:0] pending,
  output logic      [qdsc_pkg::RES_BITS-1:0] out_latch
);

  logic transparent;
  // Load pin held low or gate bit set keeps the latch transparent
  assign transparent = gate | hw_load;

  // ------------------------------------------------------------
  // Pending register
  // ------------------------------------------------------------
  // Zero wins over any write in the same cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pending <= qdsc_pkg::CODE_RESET;
    end else if (ce) begin
      if (zero) begin
        pending <= qdsc_pkg::CODE_RESET;
      end else if (write_en) begin
        pending <= write_data;
      end
    end
  end

  // ------------------------------------------------------------
  // Output latch
  // ------------------------------------------------------------
  // Transparent mode follows the newest pending value next cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      out_latch <= qdsc_pkg::CODE_RESET;
    end else if (ce) begin
      if (zero) begin
        out_latch <= qdsc_pkg::CODE_RESET;
      end else if (direct_en) begin
        out_latch <= write_data;
      end else if (xfer_en || transparent) begin
        out_latch <= pending;
      end
    end
  end

endmodule : qdsc_channel

/* tb/qdsc_host.sv */
// Host model driving the three wire serial link of the converter block
`timescale 1ns/10ps
module qdsc_host (
  output logic select_n,
  output logic sclk,
  output logic din
);
  // Link idles with select high and the serial clock parked high
  initial begin
    select_n = 1'b1;
    sclk     = 1'b1;
    din      = 1'b0;
  end

  // ----------------------------------------------------------------
  // Frame tasks
  // ----------------------------------------------------------------
  // Sends n bits MSB first; quiet keeps select high to test sharing
  task automatic send(input int n, input logic [31:0] word,
                      input bit keep, input bit quiet);
    select_n = quiet;
    #100;
    for (int i = 0; i < n; i++) begin
      din = word[31-i];
      #100 sclk = 1'b0;
      #100 sclk = 1'b1;
    end
    if (!keep) close();
  endtask : send

  // Select high then a gap; data line shows no stale bit once released
  task automatic close();
    #100;
    select_n = 1'b1;
    din      = ~din;
    #300;
  endtask : close
endmodule : qdsc_host

/* tb/testbench.sv */
// Self-checking bench for the quad converter serial control block
`timescale 1ns/10ps
module testbench;
  logic        clk;
  logic        rstn;
  logic        hw_transfer_n;
  logic        async_zero_n;
  logic        select_n;
  logic        sclk;
  logic        din;
  logic        ready_n;
  logic [11:0] out_a;
  logic [11:0] out_b;
  logic [11:0] out_c;
  logic [11:0] out_d;
  logic [1:0]  ref_mode;
  logic        ref_always_on;
  logic [7:0]  power_mode;
  logic [3:0]  latch_gate;
  int          errors;
  int          samples_checked;
  int          cycles;
  // Rows: command, word, expected a b c d, expected reference mode
  logic [73:0] rows [11] = '{
    {8'h00, 16'h1230, 12'h000, 12'h000, 12'h000, 12'h000, 2'h0},
    {8'h10, 16'h0000, 12'h123, 12'h000, 12'h000, 12'h000, 2'h0},
    {8'h31, 16'h4560, 12'h123, 12'h456, 12'h000, 12'h000, 2'h0},
    {8'h02, 16'h7890, 12'h123, 12'h456, 12'h000, 12'h000, 2'h0},
    {8'h23, 16'habc0, 12'h123, 12'h456, 12'h789, 12'habc, 2'h0},
    {8'h41, 16'h0f00, 12'h123, 12'h456, 12'h789, 12'habc, 2'h0},
    {8'h80, 16'h5550, 12'h123, 12'h456, 12'h789, 12'habc, 2'h0},
    {8'h81, 16'h0000, 12'h555, 12'h555, 12'h555, 12'h555, 2'h0},
    {8'h50, 16'h0000, 12'h000, 12'h000, 12'h000, 12'h000, 2'h0},
    {8'h82, 16'hfffa, 12'hfff, 12'hfff, 12'hfff, 12'hfff, 2'h0},
    {8'h71, 16'h0000, 12'hfff, 12'hfff, 12'hfff, 12'hfff, 2'h1}};

  qdsc_host i_qdsc_host (.select_n(select_n), .sclk(sclk), .din(din));

  qdsc_top i_qdsc_top (
    .clk(clk), .rstn(rstn), .ce(1'b1), .select_n(select_n),
    .sclk(sclk), .din(din), .hw_transfer_n(hw_transfer_n),
    .async_zero_n(async_zero_n), .ready_n(ready_n), .out_a(out_a),
    .out_b(out_b), .out_c(out_c), .out_d(out_d), .ref_mode(ref_mode),
    .ref_always_on(ref_always_on), .power_mode(power_mode),
    .latch_gate(latch_gate));

  // ----------------------------------------------------------------
  // Clock, timeout and checking helpers
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Generous ceiling, about four times the expected run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      finish_test();
    end
  end

  task automatic check(input string name, input logic [11:0] seen,
                       input logic [11:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic outs(input logic [11:0] a, b, c, d);
    check("out_a", out_a, a);
    check("out_b", out_b, b);
    check("out_c", out_c, c);
    check("out_d", out_d, d);
  endtask : outs

  // Full 24 bit frame, then settle time for the extra output stage
  task automatic frame(input logic [7:0] cmd, input logic [15:0] word);
    i_qdsc_host.send(24, {cmd, word, 8'h00}, 1'b0, 1'b0);
    repeat (8) @(negedge clk);
  endtask : frame

  task automatic finish_test();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : finish_test

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    errors          = 0;
    samples_checked = 0;
    rstn            = 1'b0;
    hw_transfer_n   = 1'b1;
    async_zero_n    = 1'b1;
    repeat (16) @(negedge clk);
    outs(12'h000, 12'h000, 12'h000, 12'h000);
    check("ready_n", {11'h0, ready_n}, 12'h001);
    check("ref_mode", {10'h0, ref_mode}, 12'h000);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    // Table rows build on each other, so order matters
    foreach (rows[i]) begin
      frame(rows[i][73:66], rows[i][65:50]);
      outs(rows[i][49:38], rows[i][37:26], rows[i][25:14],
           rows[i][13:2]);
      check("ref_mode", {10'h0, ref_mode}, {10'h0, rows[i][1:0]});
    end
    check("power_mode", {4'h0, power_mode}, 12'h055);
    // Reference kept powered, then soft default must undo it
    frame(8'h76, 16'h0000);
    check("ref_always_on", {11'h0, ref_always_on}, 12'h001);
    check("ref_mode", {10'h0, ref_mode}, 12'h002);
    frame(8'h51, 16'h0000);
    outs(12'h000, 12'h000, 12'h000, 12'h000);
    check("ref_mode", {10'h0, ref_mode}, 12'h000);
    check("ref_always_on", {11'h0, ref_always_on}, 12'h000);
    check("power_mode", {4'h0, power_mode}, 12'h000);
    // Clock activity with select high must leave everything alone
    i_qdsc_host.send(24, 32'h82777000, 1'b0, 1'b1);
    repeat (8) @(negedge clk);
    outs(12'h000, 12'h000, 12'h000, 12'h000);
    // Frame cut one bit short is dropped
    i_qdsc_host.send(23, 32'h82111000, 1'b1, 1'b0);
    repeat (8) @(negedge clk);
    check("ready_n", {11'h0, ready_n}, 12'h001);
    i_qdsc_host.close();
    repeat (8) @(negedge clk);
    outs(12'h000, 12'h000, 12'h000, 12'h000);
    // Long frame: first 24 bits count, ready stays low until select rises
    i_qdsc_host.send(30, 32'h822220ff, 1'b1, 1'b0);
    repeat (8) @(negedge clk);
    check("ready_n", {11'h0, ready_n}, 12'h000);
    outs(12'h222, 12'h222, 12'h222, 12'h222);
    i_qdsc_host.close();
    check("ready_n", {11'h0, ready_n}, 12'h001);
    // Load pin copies pending, then stays transparent while low
    frame(8'h80, 16'h3330);
    check("out_a", out_a, 12'h222);
    hw_transfer_n = 1'b0;
    repeat (6) @(negedge clk);
    outs(12'h333, 12'h333, 12'h333, 12'h333);
    frame(8'h80, 16'h4440);
    outs(12'h444, 12'h444, 12'h444, 12'h444);
    hw_transfer_n = 1'b1;
    // Gate channel A open: its writes pass straight to the output
    frame(8'h61, 16'h0100);
    check("latch_gate", {8'h0, latch_gate}, 12'h001);
    frame(8'h80, 16'h6660);
    outs(12'h666, 12'h444, 12'h444, 12'h444);
    // Clear pin in mid-frame zeroes registers and kills the frame
    fork
      i_qdsc_host.send(24, 32'h82999000, 1'b0, 1'b0);
      begin
        repeat (96) @(negedge clk);
        async_zero_n = 1'b0;
        repeat (4) @(negedge clk);
        async_zero_n = 1'b1;
      end
    join
    repeat (8) @(negedge clk);
    outs(12'h000, 12'h000, 12'h000, 12'h000);
    // Pending registers were zeroed too, and later frames run again
    frame(8'h81, 16'h0000);
    outs(12'h000, 12'h000, 12'h000, 12'h000);
    frame(8'h82, 16'h7770);
    outs(12'h777, 12'h777, 12'h777, 12'h777);
    finish_test();
  end
endmodule : testbench
